// [bench/imsep_eeprom_model.sv]
`timescale 1ns/1ps

// ****************************************
// Serial EEPROM partner
// ****************************************
module imsep_eeprom_model #(
  parameter logic [2:0] ADDR_SEL = 3'h5,
  parameter logic [3:0] DEV_CODE = 4'hA
) (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Write protect
  input wire logic wp,
  // Data pull-down
  output logic sda_oe
);
  logic [7:0] mem [256];
  logic [7:0] sh, tx, ptr;
  logic act, sel, rd, first, got_ptr, in_ack;
  int cnt;
  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7);
  end
  // Start or repeated start reframes
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    first = 1'b1;
    sel = 1'b0;
    rd = 1'b0;
    cnt = 0;
    in_ack = 1'b0;
    sda_oe = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    sda_oe = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda};
      cnt++;
    end else begin
      cnt = 0;
      if (rd && sda) sel = 1'b0;
    end
  end
  // Drive only while the clock is low
  always @(negedge scl) if (act) begin
    if (cnt == 8 && !in_ack) begin
      in_ack = 1'b1;
      if (first) begin
        first = 1'b0;
        got_ptr = 1'b0;
        sel = (sh[7:1] == {DEV_CODE, ADDR_SEL});
        rd = sh[0];
        sda_oe = sel;
      end else if (!rd && sel) begin
        if (got_ptr && !wp) mem[ptr] = sh;
        ptr = got_ptr ? ptr + 8'h01 : sh;
        got_ptr = 1'b1;
        sda_oe = 1'b1;
      end else sda_oe = 1'b0;
    end else if (cnt == 0 && in_ack) begin
      in_ack = 1'b0;
      tx = mem[ptr];
      if (sel && rd) ptr = ptr + 8'h01;
      sda_oe = sel && rd && !tx[7];
    end else if (cnt < 8 && sel && rd) sda_oe = !tx[7-cnt];
  end
endmodule : imsep_eeprom_model

// [bench/imsep_top_tb.sv]
`timescale 1ns/1ps

module imsep_top_tb;
  localparam logic [7:0] AW = 8'hAA;
  localparam logic [7:0] AR = 8'hAB;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [11:0] cmd_data = 12'h000;
  logic rate_fast = 1'b0;
  logic rate_custom = 1'b0;
  logic [15:0] clk_divisor = 16'h0095;
  logic wp_request = 1'b0;
  logic cmd_ready, rx_valid, rx_acked, busy, low_gpio_bit_zero, m_oe;
  logic scl_o, scl_oe, sda_o, sda_oe, refused;
  logic [7:0] rx_data;
  logic [7:0] shadow [256];
  logic [11:0] cq [$];
  logic [7:0] ed [$];
  logic [7:0] gd [$];
  logic ea [$];
  logic ga [$];
  realtime t_rise [$];
  realtime t_sclr = 0, t_sta = 0;
  int fail_count = 0, num_checks = 0, n_sta = 0, n_sto = 0;
  logic [31:0] rs = 32'h39;
  wire scl = !scl_oe;
  wire sda = !sda_oe && !m_oe;

  imsep_top i_imsep_top (
    .clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .rate_fast(rate_fast),
    .rate_custom(rate_custom), .clk_divisor(clk_divisor),
    .wp_request(wp_request), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_acked(rx_acked), .busy(busy), .serial_clock_out_pin_o(scl_o),
    .serial_clock_out_pin_oe(scl_oe), .serial_data_out_pin_o(sda_o),
    .serial_data_out_pin_oe(sda_oe), .serial_data_in_pin(sda),
    .low_gpio_bit_zero(low_gpio_bit_zero)
  );
  imsep_eeprom_model #(.ADDR_SEL(3'h5)) i_imsep_eeprom_model (
    .scl(scl), .sda(sda), .wp(low_gpio_bit_zero), .sda_oe(m_oe)
  );

  // ****************************************
  // Compare and helper tasks
  // ****************************************
  task automatic chk_bit(string nm, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic chk_time(string nm, real lo, real hi, real g);
    num_checks++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("[ERR] %s expected %0.1f..%0.1f seen %0.1f", nm, lo, hi, g);
    end
  endtask : chk_time
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd
  function automatic logic [11:0] cw(logic s, p, r, n, logic [7:0] b);
    return {s, p, r, n, b};
  endfunction : cw
  task automatic put(logic [11:0] w, logic [7:0] d, logic a);
    cq.push_back(w);
    ed.push_back(d);
    ea.push_back(a);
  endtask : put
  // Push queued words, wait for idle, compare byte results
  task automatic go(int ns, int np);
    n_sta = 0;
    n_sto = 0;
    refused = 1'b0;
    foreach (cq[i]) begin
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_data = cq[i];
      while (cmd_ready !== 1'b1) begin
        refused = 1'b1;
        @(negedge clk_sys);
      end
      @(posedge clk_sys);
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (int i = 0; i < 80000 && busy !== 1'b0; i++) @(negedge clk_sys);
    repeat (8) @(negedge clk_sys);
    chk_bit("busy", 1'b0, busy);
    chk_byte("rx count", 8'(ed.size()), 8'(gd.size()));
    while (ed.size() > 0 && gd.size() > 0) begin
      chk_byte("rx_data", ed.pop_front(), gd.pop_front());
      chk_bit("rx_acked", ea.pop_front(), ga.pop_front());
    end
    chk_byte("starts", 8'(ns), 8'(n_sta));
    chk_byte("stops", 8'(np), 8'(n_sto));
    cq.delete();
    ed.delete();
    ea.delete();
    gd.delete();
    ga.delete();
  endtask : go
  task automatic wr(logic [7:0] p, int n);
    logic [7:0] d;
    put(cw(1, 0, 0, 0, AW), AW, 1'b1);
    put(cw(0, 0, 0, 0, p), p, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      put(cw(0, i == n - 1, 0, 0, d), d, 1'b1);
      if (!wp_request) shadow[8'(p + i)] = d;
    end
    go(1, 1);
  endtask : wr
  task automatic rd(logic [7:0] p, int n);
    put(cw(1, 0, 0, 0, AW), AW, 1'b1);
    put(cw(0, 0, 0, 0, p), p, 1'b1);
    put(cw(1, 0, 0, 0, AR), AR, 1'b1);
    for (int i = 0; i < n; i++)
      put(cw(0, i == n - 1, 1, i == n - 1, 8'hFF), shadow[8'(p + i)],
          i != n - 1);
    go(2, 1);
  endtask : rd
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ****************************************
  // Bus and result monitors
  // ****************************************
  always @(negedge sda) if (reset_n && scl === 1'b1) begin
    n_sta++;
    chk_time("start setup", 600, 1.0e9, $realtime - t_sclr);
    t_sta = $realtime;
  end
  always @(posedge sda) if (reset_n && scl === 1'b1) begin
    n_sto++;
    chk_time("stop setup", 600, 1.0e9, $realtime - t_sclr);
  end
  always @(negedge scl) if (t_sta > 0) begin
    chk_time("start hold", 600, 1.0e9, $realtime - t_sta);
    t_sta = 0;
  end
  always @(posedge scl) begin
    t_sclr = $realtime;
    t_rise.push_back($realtime);
  end
  // Registered outputs are sampled half a cycle after they launch
  always @(negedge clk_sys) begin
    if (reset_n) chk_bit("pin level", 1'b0, scl_o | sda_o);
    if (rx_valid === 1'b1) begin
      gd.push_back(rx_data);
      ga.push_back(rx_acked);
    end
  end

  initial forever #12.5 clk_sys = ~clk_sys;
  initial begin
    #2_400_000;
    fail_count++;
    $display("[ERR] watchdog expected done seen hang");
    complete_run();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [15:0] dv [3];
    logic [7:0] p;
    real per;
    dv = '{16'h012B, 16'h004A, 16'h0095};
    for (int i = 0; i < 256; i++) shadow[i] = 8'(i * 7);
    repeat (5) @(negedge clk_sys);
    chk_bit("reset scl oe", 1'b0, scl_oe);
    chk_bit("reset sda oe", 1'b0, sda_oe);
    chk_bit("reset ready", 1'b1, cmd_ready);
    chk_bit("reset busy", 1'b0, busy);
    chk_bit("reset wp", 1'b0, low_gpio_bit_zero);
    reset_n = 1'b1;
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      rate_fast = (m == 1);
      rate_custom = (m == 2);
      per = (1 + dv[m]) * 100.0 / 3.0;
      t_rise.delete();
      put(cw(1, 1, 0, 0, AW), AW, 1'b1);
      go(1, 1);
      chk_byte("scl pulses", 8'h0A, 8'(t_rise.size()));
      if (t_rise.size() > 8)
        chk_time("scl 8 periods", 8 * per - 150, 8 * per + 150,
                 t_rise[8] - t_rise[0]);
    end
    rate_fast = 1'b1;
    rate_custom = 1'b0;
    $display("test rates done");
    p = rnd();
    wr(p, 2);
    rd(p, 2);
    $display("test write read done");
    put(cw(1, 1, 0, 0, 8'hA2), 8'hA2, 1'b0);
    go(1, 1);
    $display("test wrong address done");
    wp_request = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_bit("wp out", 1'b1, low_gpio_bit_zero);
    wr(p, 1);
    wp_request = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk_bit("wp out", 1'b0, low_gpio_bit_zero);
    rd(p, 1);
    $display("test write protect done");
    wr(8'h40, 40);
    chk_bit("cmd refused", 1'b1, refused);
    rd(8'h40, 3);
    $display("test fifo fill done");
    complete_run();
  end
endmodule : imsep_top_tb

// [rtl/imsep_cfg.svh]
`ifndef IMSEP_CFG_SVH
`define IMSEP_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define IMSEP_REF_MHZ 60
`define IMSEP_SYS_MHZ 40
`define IMSEP_CLK_NS 25
`define IMSEP_BUS_HOLD_NS 600
`define IMSEP_BUS_HOLD_CYC \
  ((`IMSEP_BUS_HOLD_NS + `IMSEP_CLK_NS - 1) / `IMSEP_CLK_NS)
`define IMSEP_MIN_PHASE_CYC 4
`define IMSEP_DIV_STD 16'h012B
`define IMSEP_DIV_FAST 16'h004A

// ****************************************************************
// Command word layout
// ****************************************************************
`define IMSEP_CMD_W 12
`define IMSEP_CMD_START 11
`define IMSEP_CMD_STOP 10
`define IMSEP_CMD_READ 9
`define IMSEP_CMD_NACK 8
`define IMSEP_BYTE_W 8
`define IMSEP_FIFO_DEPTH 32
`define IMSEP_FIFO_AW 5

`endif

// [rtl/imsep_fifo.sv]
`timescale 1ns/1ps

module imsep_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;

  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (do_pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (do_push && !do_pop) count_ff <= count_ff + 1'b1;
      else if (do_pop && !do_push) count_ff <= count_ff - 1'b1;
    end
  end

endmodule : imsep_fifo

// [rtl/imsep_pkg.sv]
package imsep_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_HOLD   = 4'h1,
    ST_RS_LO  = 4'h2,
    ST_STA_A  = 4'h3,
    ST_STA_B  = 4'h4,
    ST_BIT_LO = 4'h5,
    ST_BIT_HI = 4'h6,
    ST_ACK_LO = 4'h7,
    ST_ACK_HI = 4'h8,
    ST_SP_LO  = 4'h9,
    ST_SP_HI  = 4'hA,
    ST_SP_REL = 4'hB
  } imsep_state_t;

endpackage : imsep_pkg

// [rtl/imsep_top.sv]
// Behaviour
// - START is SDA falling while SCL is released high.
// - STOP is SDA rising while SCL is released high.
// - Only this master creates START and STOP; slaves never do.
// - Every byte is eight bits followed by one acknowledge slot.
// - Byte bits go out and come in most significant bit first.
// - Master clocks every bit, including the acknowledge pulse.
// - Transmitter releases SDA during the acknowledge clock pulse.
// - Receiver acknowledges by holding SDA low through acknowledge high.
// - First byte after START carries 7-bit address and direction bit.
// - Master ends a transfer with a STOP only after a byte whose command sets the stop bit.
// - No limit on bytes between one START and its STOP.
// - Pins only pull low or release; pull-ups make the high.
// - Serial clock rate comes from an internal divisor.
// - Data out and data in pins share the single data line.
// - Write-protect output is low normally, high only to block writes.
// - Divisor supports 100 kbit/s standard and 400 kbit/s fast.
// - Each channel instantiates its own copy of this master.
// - SCL equals 60 MHz over twice one plus the divisor.
// - START and STOP setup and hold last at least 600 ns.
`timescale 1ns/1ps
`include "imsep_cfg.svh"

module imsep_top #(
  parameter int FIFO_DEPTH = `IMSEP_FIFO_DEPTH,
  parameter int FIFO_AW = `IMSEP_FIFO_AW
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Command stream: start, stop, read, nack, byte
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [`IMSEP_CMD_W-1:0] cmd_data,
  // Rate selection
  input wire logic rate_fast,
  input wire logic rate_custom,
  input wire logic [15:0] clk_divisor,
  // Write protect request
  input wire logic wp_request,
  // Byte results
  output logic rx_valid,
  output logic [`IMSEP_BYTE_W-1:0] rx_data,
  output logic rx_acked,
  output logic busy,
  // Bus pins
  output logic serial_clock_out_pin_o,
  output logic serial_clock_out_pin_oe,
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe,
  input wire logic serial_data_in_pin,
  output logic low_gpio_bit_zero
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  imsep_pkg::imsep_state_t state_ff;
  imsep_pkg::imsep_state_t nxt_state;
  logic [23:0] acc_ff;
  logic [7:0] timer_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] cur_byte_ff;
  logic read_ff;
  logic nack_ff;
  logic stop_ff;
  logic scl_drv_ff;
  logic sda_drv_ff;
  logic sda_meta_ff;
  logic sda_sync_ff;
  logic rx_valid_ff;
  logic [7:0] rx_data_ff;
  logic rx_acked_ff;
  logic wp_ff;
  logic fifo_valid;
  logic [`IMSEP_CMD_W-1:0] fifo_data;

  // ****************************************************************
  // Command buffer
  // ****************************************************************
  wire idle_or_hold = (state_ff == imsep_pkg::ST_IDLE) ||
                      (state_ff == imsep_pkg::ST_HOLD);
  wire pop = idle_or_hold && fifo_valid;

  imsep_fifo #(
    .WIDTH(`IMSEP_CMD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_cmd_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_data),
    .out_ready(pop),
    .out_valid(fifo_valid),
    .out_data(fifo_data)
  );

  wire cmd_start = fifo_data[`IMSEP_CMD_START];
  wire cmd_stop = fifo_data[`IMSEP_CMD_STOP];
  wire cmd_read = fifo_data[`IMSEP_CMD_READ];
  wire cmd_nack = fifo_data[`IMSEP_CMD_NACK];
  wire [7:0] cmd_byte = fifo_data[`IMSEP_BYTE_W-1:0];

  // ****************************************************************
  // Half-period tick from the divisor
  // ****************************************************************
  // Accumulator emulates the 60 MHz reference on the 40 MHz clock
  wire [15:0] div_sel = rate_custom ? clk_divisor :
                        (rate_fast ? `IMSEP_DIV_FAST : `IMSEP_DIV_STD);
  wire [23:0] div_target_raw = 24'(({8'h00, div_sel} + 24'h000001) *
                                   24'(`IMSEP_SYS_MHZ));
  wire [23:0] ref_step = 24'(`IMSEP_REF_MHZ);
  // Clamp keeps at most one tick per clock cycle
  wire [23:0] div_target = (div_target_raw < ref_step) ? ref_step :
                           div_target_raw;
  wire [23:0] acc_sum = acc_ff + ref_step;
  wire tick = (acc_sum >= div_target);
  wire [23:0] nxt_acc = tick ? (acc_sum - div_target) : acc_sum;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) acc_ff <= '0;
    else acc_ff <= nxt_acc;
  end

  // ****************************************************************
  // Phase timing
  // ****************************************************************
  wire long_phase = (state_ff == imsep_pkg::ST_STA_A) ||
                    (state_ff == imsep_pkg::ST_STA_B) ||
                    (state_ff == imsep_pkg::ST_SP_HI) ||
                    (state_ff == imsep_pkg::ST_SP_REL);
  wire [7:0] need_cyc = long_phase ? 8'(`IMSEP_BUS_HOLD_CYC) :
                        8'(`IMSEP_MIN_PHASE_CYC);
  wire adv = tick && (timer_ff >= need_cyc);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) timer_ff <= '0;
    else if (nxt_state != state_ff) timer_ff <= '0;
    else if (timer_ff != 8'hFF) timer_ff <= timer_ff + 8'h01;
  end

  // ****************************************************************
  // Data line input synchroniser
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
    end else begin
      sda_meta_ff <= serial_data_in_pin;
      sda_sync_ff <= sda_meta_ff;
    end
  end

  // ****************************************************************
  // Bus sequencer
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      imsep_pkg::ST_IDLE: begin
        if (fifo_valid) nxt_state = imsep_pkg::ST_STA_A;
      end
      imsep_pkg::ST_HOLD: begin
        if (fifo_valid) begin
          nxt_state = cmd_start ? imsep_pkg::ST_RS_LO :
                      imsep_pkg::ST_BIT_LO;
        end
      end
      imsep_pkg::ST_RS_LO: if (adv) nxt_state = imsep_pkg::ST_STA_A;
      imsep_pkg::ST_STA_A: if (adv) nxt_state = imsep_pkg::ST_STA_B;
      imsep_pkg::ST_STA_B: if (adv) nxt_state = imsep_pkg::ST_BIT_LO;
      imsep_pkg::ST_BIT_LO: if (adv) nxt_state = imsep_pkg::ST_BIT_HI;
      imsep_pkg::ST_BIT_HI: begin
        if (adv) begin
          nxt_state = (bit_cnt_ff == 3'h7) ? imsep_pkg::ST_ACK_LO :
                      imsep_pkg::ST_BIT_LO;
        end
      end
      imsep_pkg::ST_ACK_LO: if (adv) nxt_state = imsep_pkg::ST_ACK_HI;
      imsep_pkg::ST_ACK_HI: begin
        if (adv) begin
          nxt_state = stop_ff ? imsep_pkg::ST_SP_LO :
                      imsep_pkg::ST_HOLD;
        end
      end
      imsep_pkg::ST_SP_LO: if (adv) nxt_state = imsep_pkg::ST_SP_HI;
      imsep_pkg::ST_SP_HI: if (adv) nxt_state = imsep_pkg::ST_SP_REL;
      imsep_pkg::ST_SP_REL: if (adv) nxt_state = imsep_pkg::ST_IDLE;
      default: nxt_state = imsep_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) state_ff <= imsep_pkg::ST_IDLE;
    else state_ff <= nxt_state;
  end

  // ****************************************************************
  // Byte shifter
  // ****************************************************************
  // First byte after START is address in 7:1 and direction in 0
  wire bit_done = (state_ff == imsep_pkg::ST_BIT_HI) && adv;
  wire ack_done = (state_ff == imsep_pkg::ST_ACK_HI) && adv;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= '0;
      cur_byte_ff <= '0;
      bit_cnt_ff <= '0;
      read_ff <= 1'b0;
      nack_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else if (pop) begin
      shift_ff <= cmd_byte;
      cur_byte_ff <= cmd_byte;
      bit_cnt_ff <= '0;
      read_ff <= cmd_read;
      nack_ff <= cmd_nack;
      stop_ff <= cmd_stop;
    end else if (bit_done) begin
      shift_ff <= {shift_ff[6:0], sda_sync_ff};
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_valid_ff <= 1'b0;
      rx_data_ff <= '0;
      rx_acked_ff <= 1'b0;
    end else begin
      rx_valid_ff <= ack_done;
      if (ack_done) begin
        rx_data_ff <= shift_ff;
        rx_acked_ff <= !sda_sync_ff;
      end
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  wire scl_low_state = (state_ff == imsep_pkg::ST_HOLD) ||
                       (state_ff == imsep_pkg::ST_RS_LO) ||
                       (state_ff == imsep_pkg::ST_BIT_LO) ||
                       (state_ff == imsep_pkg::ST_ACK_LO) ||
                       (state_ff == imsep_pkg::ST_SP_LO);
  wire in_bit = (state_ff == imsep_pkg::ST_BIT_LO) ||
                (state_ff == imsep_pkg::ST_BIT_HI);
  wire in_ack = (state_ff == imsep_pkg::ST_ACK_LO) ||
                (state_ff == imsep_pkg::ST_ACK_HI);
  wire sda_low_state = (state_ff == imsep_pkg::ST_HOLD) ||
                       (state_ff == imsep_pkg::ST_STA_B) ||
                       (state_ff == imsep_pkg::ST_SP_LO) ||
                       (state_ff == imsep_pkg::ST_SP_HI);
  wire sda_bit = in_bit && !read_ff && !shift_ff[7];
  wire sda_ack = in_ack && read_ff && !nack_ff;
  wire sda_want = sda_low_state || sda_bit || sda_ack;
  // Data changes one cycle after SCL falls, never together with it
  wire sda_freeze = scl_low_state && (timer_ff == 8'h00);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_drv_ff <= 1'b0;
      sda_drv_ff <= 1'b0;
      wp_ff <= 1'b0;
    end else begin
      scl_drv_ff <= scl_low_state;
      sda_drv_ff <= sda_freeze ? sda_drv_ff : sda_want;
      wp_ff <= wp_request;
    end
  end

  // Open drain: output value is always low, enable pulls
  assign serial_clock_out_pin_o = 1'b0;
  assign serial_data_out_pin_o = 1'b0;
  assign serial_clock_out_pin_oe = scl_drv_ff;
  assign serial_data_out_pin_oe = sda_drv_ff;
  // One copy per channel drives its own write-protect line
  assign low_gpio_bit_zero = wp_ff;
  assign rx_valid = rx_valid_ff;
  assign rx_data = rx_data_ff;
  assign rx_acked = rx_acked_ff;
  assign busy = (state_ff != imsep_pkg::ST_IDLE) || fifo_valid;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_START_EDGE: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    ($rose(sda_drv_ff) && !scl_drv_ff) |->
      ($past(state_ff) == imsep_pkg::ST_STA_B))
    else $error("SDA fell with SCL high outside START");

  AST_STOP_EDGE: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    ($fell(sda_drv_ff) && !scl_drv_ff) |->
      ($past(state_ff) == imsep_pkg::ST_SP_REL))
    else $error("SDA rose with SCL high outside STOP");

  AST_EIGHT_BITS: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(state_ff == imsep_pkg::ST_ACK_LO) |->
      ($past(bit_cnt_ff) == 3'h7))
    else $error("Acknowledge slot not after eighth bit");

  AST_MSB_FIRST: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (state_ff == imsep_pkg::ST_BIT_HI && !read_ff && timer_ff > 8'h01)
      |-> (sda_drv_ff == !cur_byte_ff[3'h7 - bit_cnt_ff]))
    else $error("Transmitted bit out of order");

  AST_ACK_CLOCKED: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (state_ff == imsep_pkg::ST_ACK_HI && timer_ff > 8'h00) |->
      !scl_drv_ff)
    else $error("SCL not released in acknowledge pulse");

  AST_TX_RELEASE: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (state_ff == imsep_pkg::ST_ACK_HI && !read_ff && timer_ff > 8'h00)
      |-> !sda_drv_ff)
    else $error("SDA held during slave acknowledge");

  AST_RX_RELEASE: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (state_ff == imsep_pkg::ST_BIT_HI && read_ff && timer_ff > 8'h00)
      |-> !sda_drv_ff)
    else $error("SDA driven during received bit");

  AST_HOLD_600: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (long_phase && nxt_state != state_ff) |->
      (timer_ff >= 8'(`IMSEP_BUS_HOLD_CYC)))
    else $error("START or STOP phase shorter than 600 ns");

  AST_WP_FOLLOW: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(low_gpio_bit_zero) |-> $past(wp_request))
    else $error("Write protect raised without request");

endmodule : imsep_top
